/* smw_pkg.sv */
package smw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR = 3'h4;

  // mode register fields
  localparam int MODE_HL_SEL_BIT = 0;
  localparam int MODE_IDLE_SEL_BIT = 1;
  localparam int MODE_HIGH_RDY_BIT = 2;
  localparam int MODE_LOW_RDY_BIT = 3;
  localparam int MODE_FAST_BIT = 4;
  localparam int MODE_DIV_LSB = 5;
  localparam logic [7:0] MODE_RESET = 8'h03;

  // configuration register fields
  localparam int CFG_KEEP_ON_BIT = 0;
  localparam int CFG_WDOG_BIT = 1;
  localparam int CFG_LVD_BIT = 2;
  localparam int CFG_HS_TYPE_LSB = 3;
  localparam int CFG_SUB_TYPE_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // oscillator kinds
  localparam logic [1:0] HS_CRYSTAL = 2'h0;
  localparam logic [1:0] HS_EXT_RC = 2'h1;
  localparam logic [1:0] HS_INT_RC = 2'h2;
  localparam logic SUB_CRYSTAL = 1'b0;
  localparam logic SUB_INT_RC = 1'b1;

  // settle counts in oscillator cycles
  localparam int READY_W = 11;
  localparam logic [READY_W-1:0] CRYSTAL_SETTLE = 11'h400;
  localparam logic [READY_W-1:0] RC_SETTLE = 11'h010;
  localparam logic [READY_W-1:0] LOW_RC_SETTLE = 11'h002;

  // divider codes and masks
  localparam logic [2:0] DIV_LOW_A = 3'h0;
  localparam logic [2:0] DIV_LOW_B = 3'h1;
  localparam logic [5:0] PERIPH16_MASK = 6'h0f;
  localparam logic [5:0] PERIPH64_MASK = 6'h3f;

  // interrupt bits
  localparam int INT_W = 4;
  localparam int INT_HIGH_RDY = 0;
  localparam int INT_LOW_RDY = 1;
  localparam int INT_WAKE = 2;
  localparam int INT_SWITCH = 3;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_IDLE_RUN, ST_IDLE_STOP, ST_SLEEP_PART,
    ST_SLEEP_FULL, ST_WAKE_SUB, ST_FAST_RUN, ST_WAKE_WAIT
  } smw_state_t;

  // mask of high-speed counter bits for the divided clock
  function automatic logic [5:0] smw_div_mask(input logic [2:0] sel);
    unique case (sel)
      3'h2: smw_div_mask = 6'h3f;
      3'h3: smw_div_mask = 6'h1f;
      3'h4: smw_div_mask = 6'h0f;
      3'h5: smw_div_mask = 6'h07;
      3'h6: smw_div_mask = 6'h03;
      default: smw_div_mask = 6'h01;
    endcase
  endfunction : smw_div_mask

endpackage : smw_pkg

/* smw_osc_watch.sv */
`timescale 1ns/10ps
`default_nettype none
module smw_osc_watch
  import smw_pkg::*;
#(
  parameter int CNT_W = READY_W
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic osc_pin, // oscillator level from pin
  input wire logic run, // oscillator enabled
  input wire logic [CNT_W-1:0] settle_count, // cycles until stable
  output logic tick, // one pulse per oscillator cycle
  output logic ready // oscillator stable
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic [CNT_W-1:0] count;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= osc_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // rising edge once second stage is high and third stage still low
  assign tick = sync2 & ~sync3 & run;

  // settle counter, cleared while stopped
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count <= '0;
      ready <= 1'b0;
    end else if (tick && !ready) begin
      count <= count + CNT_W'(1);
      if (count + CNT_W'(1) >= settle_count) begin
        ready <= 1'b1;
      end
    end
  end

endmodule : smw_osc_watch
`default_nettype wire

/* smw_ctrl.sv */
// Notes on behaviour
// RQ1: low ready flag low in full sleep; rises after 1024 crystal or 2 rc cycles.
// RQ2: fast wake from crystal: raise high ready when stable, then move to crystal.
// RQ3: halt enters idle when idle select is one, sleep when zero.
// RQ4: idle keeps system clock if keep-on set, else stops it with processor.
// RQ5: select clears to divided or low clock per divider select; set gives full rate.
// RQ6: running from low clock stops the high oscillator and its peripheral clocks.
// RQ7: select clear with divider 000 or 001 enters slow mode.
// RQ8: slow mode switch completes only once the low oscillator reports ready.
// RQ9: fast wake runs the system from the sub clock until main oscillator settles.
// RQ10: fast wake only from partial sleep or clock-stopped idle, never full sleep.
// RQ11: crystal fast wake starts within 1~2 sub cycles, runs sub until 1024 cycles.
// RQ12: rc main oscillators wake after 16 cycles, ignoring fast wake enable.
// RQ13: watchdog off leaves low oscillators off, so no fast wake from full sleep; the code stops the sub oscillator only in full sleep.
// RQ14: select set, or divider 010 to 111, returns to normal mode.
// RQ15: sleep is full with watchdog and detector off, partial when either is on.
// RQ16: clock source changes only on a safe edge of old and new clocks.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module smw_ctrl
  import smw_pkg::*;
(
  input wire logic clk, // system clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic hs_osc_pin, // high-speed oscillator level
  input wire logic sub_osc_pin, // sub oscillator level
  input wire logic halt_req, // halt instruction pulse
  input wire logic wake_req, // wake-up source pulse
  input wire logic [ADDR_W-1:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic sys_clk_en, // system clock enable pulse
  output logic periph_div16_en, // high clock divided by 16
  output logic periph_div64_en, // high clock divided by 64
  output logic cpu_run, // processor may execute
  output logic high_osc_enable, // high-speed oscillator on
  output logic sub_osc_enable, // sub oscillator on
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  smw_state_t state;
  smw_state_t next_state;
  logic [2:0] clock_divider_select;
  logic fast_wake_enable;
  logic idle_select;
  logic high_low_clock_select;
  logic idle_clock_keep_on;
  logic watchdog_on;
  logic lvd_on;
  logic [1:0] hs_osc_type;
  logic sub_osc_type;
  logic high_osc_ready_flag;
  logic low_osc_ready_flag;
  logic high_rdy_prev;
  logic low_rdy_prev;
  logic hs_tick;
  logic sub_tick;
  logic [READY_W-1:0] hs_settle;
  logic [READY_W-1:0] sub_settle;
  logic [5:0] hs_div_cnt;
  logic [5:0] div_mask;
  logic div_tick;
  logic hs_path_tick;
  logic slow_req;
  logic src_low;
  logic want_low;
  logic old_seen;
  logic old_tick;
  logic new_tick;
  logic switch_done;
  logic clock_live;
  logic fast_ok;
  logic wake_done;
  logic next_high_osc;
  logic [INT_W-1:0] int_event;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_enable;
  logic [INT_W-1:0] int_clear;

  // ----------------------------------------------------------------
  // oscillator watchers
  // ----------------------------------------------------------------
  // settle length follows the oscillator kind
  assign hs_settle = (hs_osc_type == HS_CRYSTAL) ? CRYSTAL_SETTLE : RC_SETTLE;
  assign sub_settle = (sub_osc_type == SUB_CRYSTAL) ? CRYSTAL_SETTLE : LOW_RC_SETTLE;

  smw_osc_watch #(
    .CNT_W(READY_W)
  ) u_hs_watch (
    .clk(clk),
    .rst(rst),
    .osc_pin(hs_osc_pin),
    .run(high_osc_enable),
    .settle_count(hs_settle),
    .tick(hs_tick),
    .ready(high_osc_ready_flag)
  );

  // RQ1 low ready timing
  smw_osc_watch #(
    .CNT_W(READY_W)
  ) u_sub_watch (
    .clk(clk),
    .rst(rst),
    .osc_pin(sub_osc_pin),
    .run(sub_osc_enable),
    .settle_count(sub_settle),
    .tick(sub_tick),
    .ready(low_osc_ready_flag)
  );

  // ----------------------------------------------------------------
  // high-speed divider
  // ----------------------------------------------------------------
  // free count of high-speed cycles
  always_ff @(posedge clk) begin
    if (rst || !high_osc_enable) begin
      hs_div_cnt <= '0;
    end else if (hs_tick) begin
      hs_div_cnt <= hs_div_cnt + 6'h01;
    end
  end

  // RQ5 divided or full rate
  assign div_mask = smw_div_mask(clock_divider_select);
  assign div_tick = hs_tick && ((hs_div_cnt & div_mask) == div_mask);
  assign hs_path_tick = high_low_clock_select ? hs_tick : div_tick;

  // RQ7 slow mode request
  assign slow_req = !high_low_clock_select &&
    (clock_divider_select == DIV_LOW_A || clock_divider_select == DIV_LOW_B);

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  assign clock_live = (state == ST_NORMAL) || (state == ST_IDLE_RUN) ||
    (state == ST_FAST_RUN);

  // wanted source; slow and normal targets wait for their ready flag, ST_WAKE_SUB and ST_FAST_RUN force the sub clock
  always_comb begin
    want_low = src_low;
    if (state == ST_WAKE_SUB || state == ST_FAST_RUN) begin
      // RQ9 sub clock while waking
      want_low = 1'b1;
    end else if (slow_req && low_osc_ready_flag) begin
      // RQ8 slow only when ready
      want_low = 1'b1;
    end else if (!slow_req && high_osc_ready_flag) begin
      // RQ14 back to normal
      want_low = 1'b0;
    end
  end

  assign old_tick = src_low ? sub_tick : hs_path_tick;
  assign new_tick = src_low ? hs_path_tick : sub_tick;
  assign switch_done = clock_live && (want_low != src_low) && old_seen && new_tick;

  // RQ16 glitch-free handover
  always_ff @(posedge clk) begin
    if (rst) begin
      src_low <= 1'b0;
      old_seen <= 1'b0;
    end else if (want_low == src_low) begin
      old_seen <= 1'b0;
    end else if (!clock_live) begin
      src_low <= want_low;
      old_seen <= 1'b0;
    end else if (!old_seen) begin
      old_seen <= old_tick;
    end else if (new_tick) begin
      src_low <= want_low;
      old_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // operating mode machine
  // ----------------------------------------------------------------
  // RQ11 fast wake needs crystal normal clock
  assign fast_ok = fast_wake_enable && (hs_osc_type == HS_CRYSTAL) && !slow_req;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_NORMAL: begin
        if (halt_req) begin
          // RQ3 idle or sleep
          if (idle_select) begin
            // RQ4 keep-on picks idle kind
            next_state = idle_clock_keep_on ? ST_IDLE_RUN : ST_IDLE_STOP;
          end else begin
            // RQ15 full or partial sleep
            next_state = (watchdog_on || lvd_on) ? ST_SLEEP_PART : ST_SLEEP_FULL;
          end
        end
      end
      ST_IDLE_RUN: begin
        if (wake_req) begin
          next_state = ST_NORMAL;
        end
      end
      ST_IDLE_STOP, ST_SLEEP_PART: begin
        // RQ10 fast wake where sub clock runs
        // RQ12 rc oscillators ignore fast wake
        if (wake_req) begin
          next_state = fast_ok ? ST_WAKE_SUB : ST_WAKE_WAIT;
        end
      end
      ST_SLEEP_FULL: begin
        // RQ13 no fast wake from full sleep
        if (wake_req) begin
          next_state = ST_WAKE_WAIT;
        end
      end
      ST_WAKE_SUB: begin
        // RQ11 wake on sub clock edge
        if (sub_tick) begin
          next_state = ST_FAST_RUN;
        end
      end
      ST_FAST_RUN: begin
        // RQ2 leave fast run when crystal ready
        if (high_osc_ready_flag) begin
          next_state = ST_NORMAL;
        end
      end
      ST_WAKE_WAIT: begin
        if (slow_req ? low_osc_ready_flag : high_osc_ready_flag) begin
          next_state = ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  assign wake_done = (state == ST_WAKE_WAIT || state == ST_WAKE_SUB ||
    state == ST_IDLE_RUN) && (next_state == ST_NORMAL || next_state == ST_FAST_RUN);

  // ----------------------------------------------------------------
  // oscillator enables
  // ----------------------------------------------------------------
  // RQ6 high oscillator off in slow mode and stopped states
  always_comb begin
    next_high_osc = 1'b1;
    if (next_state == ST_IDLE_STOP || next_state == ST_SLEEP_PART ||
        next_state == ST_SLEEP_FULL) begin
      next_high_osc = 1'b0;
    end else if (src_low && want_low && slow_req && next_state != ST_FAST_RUN &&
        next_state != ST_WAKE_SUB) begin
      next_high_osc = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_osc_enable <= 1'b1;
      sub_osc_enable <= 1'b1;
    end else begin
      high_osc_enable <= next_high_osc;
      // RQ13 sub clock stops only in full sleep
      sub_osc_enable <= (next_state != ST_SLEEP_FULL);
    end
  end

  // ----------------------------------------------------------------
  // clock enables to the system
  // ----------------------------------------------------------------
  // RQ4 system clock only in live states
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_clk_en <= 1'b0;
      cpu_run <= 1'b1;
      periph_div16_en <= 1'b0;
      periph_div64_en <= 1'b0;
    end else begin
      sys_clk_en <= clock_live && old_tick;
      cpu_run <= (next_state == ST_NORMAL) || (next_state == ST_FAST_RUN);
      periph_div16_en <= hs_tick && ((hs_div_cnt & PERIPH16_MASK) == PERIPH16_MASK);
      periph_div64_en <= hs_tick && ((hs_div_cnt & PERIPH64_MASK) == PERIPH64_MASK);
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      high_low_clock_select <= MODE_RESET[MODE_HL_SEL_BIT];
      idle_select <= MODE_RESET[MODE_IDLE_SEL_BIT];
      fast_wake_enable <= MODE_RESET[MODE_FAST_BIT];
      clock_divider_select <= MODE_RESET[MODE_DIV_LSB +: 3];
    end else if (reg_wr && reg_addr == ADDR_MODE) begin
      high_low_clock_select <= reg_wdata[MODE_HL_SEL_BIT];
      idle_select <= reg_wdata[MODE_IDLE_SEL_BIT];
      fast_wake_enable <= reg_wdata[MODE_FAST_BIT];
      clock_divider_select <= reg_wdata[MODE_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_clock_keep_on <= CFG_RESET[CFG_KEEP_ON_BIT];
      watchdog_on <= CFG_RESET[CFG_WDOG_BIT];
      lvd_on <= CFG_RESET[CFG_LVD_BIT];
      hs_osc_type <= CFG_RESET[CFG_HS_TYPE_LSB +: 2];
      sub_osc_type <= CFG_RESET[CFG_SUB_TYPE_BIT];
    end else if (reg_wr && reg_addr == ADDR_CFG) begin
      idle_clock_keep_on <= reg_wdata[CFG_KEEP_ON_BIT];
      watchdog_on <= reg_wdata[CFG_WDOG_BIT];
      lvd_on <= reg_wdata[CFG_LVD_BIT];
      hs_osc_type <= reg_wdata[CFG_HS_TYPE_LSB +: 2];
      sub_osc_type <= reg_wdata[CFG_SUB_TYPE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      high_rdy_prev <= 1'b0;
      low_rdy_prev <= 1'b0;
    end else begin
      high_rdy_prev <= high_osc_ready_flag;
      low_rdy_prev <= low_osc_ready_flag;
    end
  end

  always_comb begin
    int_event = '0;
    int_event[INT_HIGH_RDY] = high_osc_ready_flag && !high_rdy_prev;
    int_event[INT_LOW_RDY] = low_osc_ready_flag && !low_rdy_prev;
    int_event[INT_WAKE] = wake_done;
    int_event[INT_SWITCH] = switch_done;
  end

  assign int_clear = (reg_wr && reg_addr == ADDR_INT_CLEAR) ? reg_wdata[INT_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~int_clear) | int_event;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_enable <= '0;
    end else if (reg_wr && reg_addr == ADDR_INT_ENABLE) begin
      int_enable <= reg_wdata[INT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_status & ~int_clear) | int_event) & int_enable);
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        ADDR_MODE: reg_rdata <= {clock_divider_select, fast_wake_enable,
          low_osc_ready_flag, high_osc_ready_flag, idle_select, high_low_clock_select};
        ADDR_CFG: reg_rdata <= {2'h0, sub_osc_type, hs_osc_type, lvd_on,
          watchdog_on, idle_clock_keep_on};
        ADDR_INT_STATUS: reg_rdata <= {{(8-INT_W){1'b0}}, int_status};
        ADDR_INT_ENABLE: reg_rdata <= {{(8-INT_W){1'b0}}, int_enable};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : smw_ctrl
`default_nettype wire

/* smw_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module smw_ctrl_chk
  import smw_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic halt_req, // halt pulse
  input wire logic wake_req, // wake pulse
  input wire logic [ADDR_W-1:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic sys_clk_en, // system clock enable
  input wire logic periph_div16_en, // divided by 16
  input wire logic periph_div64_en, // divided by 64
  input wire logic cpu_run, // processor runs
  input wire logic high_osc_enable, // high oscillator on
  input wire logic sub_osc_enable, // sub oscillator on
  input wire logic irq // interrupt level
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic woke; // a wake request came after the last halt

  // remembers whether a wake request followed the last halt
  always_ff @(posedge clk) begin
    if (rst) begin
      woke <= 1'b0;
    end else if (wake_req) begin
      woke <= 1'b1;
    end else if (halt_req) begin
      woke <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // halt stops processor
  halt_stop_a: assert property ($fell(cpu_run) |-> $past(halt_req))
    else $error("processor stopped without a halt");
  wake_cause_a: assert property ($rose(cpu_run) |-> woke)
    else $error("processor restarted without a wake request");
  full_stop_a: assert property ($fell(sub_osc_enable) |->
    !high_osc_enable && !cpu_run && $past(halt_req))
    else $error("sub oscillator stopped outside a full sleep entry");
  div_stop_a: assert property (!high_osc_enable [*6] |->
    !periph_div16_en && !periph_div64_en)
    else $error("divided clock pulse with high oscillator off");
  clk_stop_a: assert property (!sub_osc_enable [*3] |-> !sys_clk_en)
    else $error("system clock pulse while all clocks are stopped");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read answer cycle");
  unmapped_read_a: assert property (reg_rd && reg_addr >= ADDR_INT_CLEAR |=> reg_rdata == 8'h00)
    else $error("clear or unmapped address read back non-zero");
  irq_mask_a: assert property (reg_wr && reg_addr == ADDR_INT_ENABLE && reg_wdata == 8'h00
    |-> ##2 !irq)
    else $error("interrupt high with all enables cleared");
endmodule : smw_ctrl_chk

bind smw_ctrl smw_ctrl_chk u_smw_ctrl_chk (.clk(clk), .rst(rst), .halt_req(halt_req),
  .wake_req(wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_clk_en(sys_clk_en),
  .periph_div16_en(periph_div16_en), .periph_div64_en(periph_div64_en), .cpu_run(cpu_run),
  .high_osc_enable(high_osc_enable), .sub_osc_enable(sub_osc_enable), .irq(irq));
`default_nettype wire

/* smw_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module smw_ctrl_bench
  import smw_pkg::*;
;
  logic clk, rst, hs_osc_pin, sub_osc_pin, halt_req, wake_req, reg_wr, reg_rd, rd_d;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic sys_clk_en, periph_div16_en, periph_div64_en, cpu_run, high_osc_enable;
  logic sub_osc_enable, irq;
  logic [7:0] exp_q[$];
  logic [7:0] mode_tab [6] = '{8'h03, 8'h03, 8'h01, 8'h11, 8'h13, 8'h13};
  logic [7:0] cfg_tab [6] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h10};
  logic [7:0] slow_tab [2] = '{8'h00, 8'h20};
  logic [7:0] back_tab [2] = '{8'h40, 8'h01};
  int quick_tab [6] = '{1, 0, 0, 0, 1, 0};
  int lim_tab [6] = '{10, 7000, 7000, 7000, 7000, 300};
  int failures, n_checks, seed, k, runs, pulses;

  smw_ctrl u_smw_ctrl (.clk(clk), .rst(rst), .hs_osc_pin(hs_osc_pin),
    .sub_osc_pin(sub_osc_pin), .halt_req(halt_req), .wake_req(wake_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_clk_en(sys_clk_en), .periph_div16_en(periph_div16_en),
    .periph_div64_en(periph_div64_en), .cpu_run(cpu_run), .high_osc_enable(high_osc_enable),
    .sub_osc_enable(sub_osc_enable), .irq(irq));

  // ----------------------------------------------------------------
  // clocks and oscillator waveforms, unrelated in phase
  // ----------------------------------------------------------------
  always #4 clk = ~clk;
  // a disabled oscillator stands still at low level
  always #24.3 hs_osc_pin = (high_osc_enable === 1'b1) ? ~hs_osc_pin : 1'b0;
  always #48.7 sub_osc_pin = (sub_osc_enable === 1'b1) ? ~sub_osc_pin : 1'b0;

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // compares each answer with the oldest noted read
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      check("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  // one-cycle halt or wake pulse
  task automatic pulse(input bit wake);
    @(posedge clk);
    wake_req <= wake;
    halt_req <= !wake;
    @(posedge clk);
    wake_req <= 1'b0;
    halt_req <= 1'b0;
  endtask : pulse

  // counts running cycles and system clock pulses
  task automatic watch(input int n, output int r, output int p);
    r = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      r += (cpu_run === 1'b1);
      p += (sys_clk_en === 1'b1);
    end
  endtask : watch

  // bounded wait for a level: 0 cpu_run, 1 high_osc_enable, 2 div16, 3 div64 enable
  task automatic await(input int sel, input logic val, input int lim, input string what);
    int n;
    logic s;
    n = 0;
    s = ~val;
    while (s !== val && n < lim) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? cpu_run : (sel == 1) ? high_osc_enable :
        (sel == 2) ? periph_div16_en : periph_div64_en;
      n++;
    end
    check(what, {7'h00, val}, {7'h00, s});
    if (s !== val) begin
      complete_run();
    end
  endtask : await

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, hs_osc_pin, sub_osc_pin, halt_req, wake_req, reg_wr, reg_rd, rd_d} = '0;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = 8'h00;
    failures = 0;
    n_checks = 0;
    seed = 32'h2ae5;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // register reset values, clear and unmapped places
    rd(ADDR_MODE, MODE_RESET);
    rd(ADDR_CFG, CFG_RESET);
    rd(ADDR_INT_STATUS, 8'h00);
    rd(ADDR_INT_ENABLE, 8'h00);
    rd(ADDR_INT_CLEAR, 8'h00);
    for (k = 5; k < 8; k++) begin
      wr(k[2:0], 8'($random(seed)));
      rd(k[2:0], 8'h00);
    end
    $display("test register reset done");
    wr(ADDR_INT_ENABLE, 8'h02);
    repeat (13000) @(posedge clk);
    rd(ADDR_MODE, 8'h0f);
    rd(ADDR_INT_STATUS, 8'h03);
    check("irq raised", 8'h01, {7'h00, irq});
    wr(ADDR_INT_CLEAR, 8'h02);
    rd(ADDR_INT_STATUS, 8'h01);
    check("irq cleared", 8'h00, {7'h00, irq});
    wr(ADDR_INT_ENABLE, 8'h00);
    $display("test ready flags done");
    for (k = 0; k < 6; k++) begin
      wr(ADDR_MODE, mode_tab[k]);
      wr(ADDR_CFG, cfg_tab[k]);
      pulse(1'b0);
      await(0, 1'b0, 2, "cpu_run halted");
      watch(40, runs, pulses);
      check("sys_clk_en in halt", {7'h00, k == 0}, {7'h00, pulses > 0});
      check("sub_osc_enable in halt", {7'h00, k != 3}, {7'h00, sub_osc_enable});
      if (k == 3) begin
        rd(ADDR_MODE, 8'h11);
      end
      pulse(1'b1);
      watch(40, runs, pulses);
      check("early wake", quick_tab[k][7:0], {7'h00, runs > 0});
      await(0, 1'b1, lim_tab[k], "cpu_run woken");
      if (k == 4) begin
        rd(ADDR_MODE, 8'h13);
        repeat (7000) @(posedge clk);
        rd(ADDR_MODE, 8'h1f);
      end
      $display("test halt case %0d done", k);
    end
    wr(ADDR_CFG, 8'h00);
    wr(ADDR_INT_ENABLE, 8'h08);
    for (k = 0; k < 2; k++) begin
      // drop switch events left by earlier source changes
      wr(ADDR_INT_CLEAR, 8'h08);
      #1;
      check("irq before switch", 8'h00, {7'h00, irq});
      wr(ADDR_MODE, slow_tab[k]);
      await(1, 1'b0, 300, "high_osc_enable slow");
      watch(60, runs, pulses);
      check("sys_clk_en slow", 8'h01, {7'h00, pulses > 0});
      check("irq switch done", 8'h01, {7'h00, irq});
      wr(ADDR_INT_CLEAR, 8'h08);
      wr(ADDR_MODE, back_tab[k]);
      await(1, 1'b1, 300, "high_osc_enable normal");
      await(2, 1'b1, 8000, "periph_div16_en");
      await(3, 1'b1, 8000, "periph_div64_en");
      repeat (7000) @(posedge clk);
      $display("test slow case %0d done", k);
    end
    complete_run();
  end
endmodule : smw_ctrl_bench
`default_nettype wire
